// ### src/tcp_host_ctrl.sv
// host controller for a three-wire configuration port: AXI4-Lite
// registers in, serial clock, chip select and shared data pin out.
// assumes the device samples on rising sclk and drives on falling.
// Behaviour
// - chip select low enables a frame; idle activity is ignored
// - frame starts at chip select fall and the following sclk rise
// - chip select may stay low for streamed bytes
// - chip select may rise between bytes to stall
// - every transfer unit is eight bits
// - leading instruction bit selects read or write; in LSB-first mode the code sends it as the 16th bit, after the address
// - on reads the data line turns round after the instruction
// - host alone drives sclk and chip select; data line shared
// - keep the port idle while full converter performance is needed
// - unassigned bits of partly used addresses are written as zero
// - never write a fully unassigned address
// - writing 0x81 to address 0 soft resets; wait 5 ms after
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module tcp_host_ctrl
#(
    parameter int RST_WAIT_CYCLES = tcp_pkg::SRST_WAIT_CYC
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sclk,
    output logic             chip_select_n,
    output logic             sdio_o,
    output logic             sdio_oe,
    input  wire logic        sdio_i
);
    import tcp_pkg::*;

    tcp_state_t  state;
    logic        cfg_read;
    logic [14:0] cfg_addr;
    logic [7:0]  cfg_wdata;
    logic [7:0]  rd_byte;
    logic        lsb_mode;
    logic        cur_rw;
    logic [23:0] tx_frame;
    logic [7:0]  rx_byte;
    logic [4:0]  bit_cnt;
    logic [20:0] wait_cnt;
    logic        tick;
    logic        sdio_s;

    tcp_tick_div u_div
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (state == S_SHIFT || state == S_DONE),
        .tick    (tick)
    );

    tcp_pin_sync u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (sdio_i),
        .level   (sdio_s)
    );

    // register bus decode
    wire        wr_fire  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire        rd_fire  = s_axi_arvalid && !s_axi_rvalid;
    wire        wr_ctrl  = wr_fire && s_axi_awaddr == REG_CTRL;
    wire        wr_addr  = wr_fire && s_axi_awaddr == REG_ADDR;
    wire        wr_wdat  = wr_fire && s_axi_awaddr == REG_WDATA;
    wire        wr_map   = wr_ctrl || wr_addr || wr_wdat;
    wire        busy     = state != S_IDLE;
    wire        go       = wr_ctrl && s_axi_wstrb[0]
                           && s_axi_wdata[CTRL_GO] && !busy;
    wire        next_rw  = s_axi_wdata[CTRL_READ];
    wire [7:0]  status   = {5'h00, lsb_mode, state == S_RWAIT, busy};
    wire        rd_map   = s_axi_araddr == REG_CTRL
                           || s_axi_araddr == REG_ADDR
                           || s_axi_araddr == REG_WDATA
                           || s_axi_araddr == REG_STATUS
                           || s_axi_araddr == REG_RDATA;
    wire [31:0] next_rdata =
        s_axi_araddr == REG_CTRL   ? {30'h0, cfg_read, 1'b0} :
        s_axi_araddr == REG_ADDR   ? {17'h0, cfg_addr} :
        s_axi_araddr == REG_WDATA  ? {24'h0, cfg_wdata} :
        s_axi_araddr == REG_STATUS ? {24'h0, status} :
        s_axi_araddr == REG_RDATA  ? {24'h0, rd_byte} : 32'h0;

    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = rd_fire;

    // serial frame decode
    wire [4:0] next_bit  = 5'(bit_cnt + 5'h01);
    wire [4:0] next_pos  = tcp_bit_pos(next_bit, lsb_mode);
    wire [4:0] rx_pos    = tcp_bit_pos(bit_cnt, lsb_mode);
    wire       rx_phase  = cur_rw && bit_cnt >= INSTR_BITS;
    wire       drv_next  = !(cur_rw && next_bit >= INSTR_BITS);
    wire       cfg_hit   = !cur_rw && tx_frame[22:8] == DEV_PORT_CFG;
    wire       srst_hit  = cfg_hit && (tx_frame[7:0] & SRST_MASK) != 8'h00;
    wire       wait_end  = wait_cnt == 21'(RST_WAIT_CYCLES - 1);
    wire [23:0] go_frame = {next_rw, cfg_addr, cfg_wdata};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_read  <= 1'b0;
            cfg_addr  <= 15'h0;
            cfg_wdata <= 8'h0;
        end
        else
        begin
            if (wr_ctrl && s_axi_wstrb[0])
                cfg_read <= next_rw;
            if (wr_addr && s_axi_wstrb[0])
                cfg_addr[7:0] <= s_axi_wdata[7:0];
            if (wr_addr && s_axi_wstrb[1])
                cfg_addr[14:8] <= s_axi_wdata[14:8];
            if (wr_wdat && s_axi_wstrb[0])
                cfg_wdata <= s_axi_wdata[7:0];
        end
    end

    // serial engine: one byte per frame, instruction then data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state         <= S_IDLE;
            sclk          <= 1'b0;
            chip_select_n <= 1'b1;
            sdio_o        <= 1'b0;
            sdio_oe       <= 1'b0;
            cur_rw        <= 1'b0;
            tx_frame      <= 24'h0;
            bit_cnt       <= 5'h0;
        end
        else
        begin
            unique case (state)
                S_IDLE:
                    if (go)
                    begin
                        state         <= S_SHIFT;
                        chip_select_n <= 1'b0;
                        cur_rw        <= next_rw;
                        tx_frame      <= go_frame;
                        bit_cnt       <= 5'h0;
                        sdio_o  <= go_frame[tcp_bit_pos(5'h0, lsb_mode)];
                        sdio_oe       <= 1'b1;
                    end
                S_SHIFT:
                    if (tick && !sclk)
                        sclk <= 1'b1;
                    else if (tick)
                    begin
                        sclk <= 1'b0;
                        if (bit_cnt == LAST_BIT)
                            state <= S_DONE;
                        else
                        begin
                            bit_cnt <= next_bit;
                            sdio_o  <= tx_frame[next_pos];
                            sdio_oe <= drv_next;
                        end
                    end
                S_DONE:
                    if (tick)
                    begin
                        chip_select_n <= 1'b1;
                        sdio_o        <= 1'b0;
                        sdio_oe       <= 1'b0;
                        state <= srst_hit ? S_RWAIT : S_IDLE;
                    end
                S_RWAIT:
                    if (wait_end)
                        state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_byte <= 8'h0;
        else if (state == S_SHIFT && tick && !sclk && rx_phase)
            rx_byte[rx_pos[2:0]] <= sdio_s;
    end

    // result byte, bit order tracking, soft reset hold-off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_byte  <= 8'h0;
            lsb_mode <= 1'b0;
            wait_cnt <= 21'h0;
        end
        else if (state == S_DONE && tick)
        begin
            wait_cnt <= 21'h0;
            if (cur_rw)
                rd_byte <= rx_byte;
            if (srst_hit)
                lsb_mode <= 1'b0;
            else if (cfg_hit)
                lsb_mode <= (tx_frame[7:0] & LSB_MASK) != 8'h00;
        end
        else if (state == S_RWAIT)
            wait_cnt <= 21'(wait_cnt + 21'h1);
    end

    // helper: rising sclk edges seen in the current frame
    logic [4:0] rise_cnt;
    logic       sclk_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rise_cnt <= 5'h0;
            sclk_q   <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk;
            if (chip_select_n)
                rise_cnt <= 5'h0;
            else if (sclk && !sclk_q)
                rise_cnt <= 5'(rise_cnt + 5'h01);
        end
    end

    property p_idle_deselect;
        @(posedge aclk) disable iff (!aresetn)
        state == S_IDLE |-> chip_select_n && !sdio_oe;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect)
        else $error("chip select or data driven while idle");

    property p_sclk_low_deselected;
        @(posedge aclk) disable iff (!aresetn)
        chip_select_n |-> !sclk;
    endproperty
    a_sclk_low_deselected: assert property (p_sclk_low_deselected)
        else $error("serial clock high while deselected");

    property p_first_bit_rw;
        @(posedge aclk) disable iff (!aresetn)
        $fell(chip_select_n) && !lsb_mode |-> sdio_o == cur_rw && sdio_oe;
    endproperty
    a_first_bit_rw: assert property (p_first_bit_rw)
        else $error("leading bit does not carry read flag");

    property p_frame_bits;
        @(posedge aclk) disable iff (!aresetn)
        $rose(chip_select_n) |-> $past(rise_cnt) == FRAME_BITS;
    endproperty
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame did not carry 24 clock edges");

    property p_read_release;
        @(posedge aclk) disable iff (!aresetn)
        state == S_SHIFT && cur_rw && rise_cnt >= INSTR_BITS
            && !sclk |-> !sdio_oe;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("data line still driven in read data phase");

    property p_write_drive;
        @(posedge aclk) disable iff (!aresetn)
        state == S_SHIFT && !cur_rw |-> sdio_oe;
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("data line released during a write");

    property p_srst_wait;
        @(posedge aclk) disable iff (!aresetn)
        $past(state) == S_DONE && state == S_RWAIT
            |-> chip_select_n && busy && !lsb_mode
            ##1 (state == S_RWAIT && chip_select_n)[*8];
    endproperty
    a_srst_wait: assert property (p_srst_wait)
        else $error("soft reset hold-off broken");

    property p_srst_entry;
        @(posedge aclk) disable iff (!aresetn)
        state == S_DONE && tick && srst_hit |=> state == S_RWAIT;
    endproperty
    a_srst_entry: assert property (p_srst_entry)
        else $error("soft reset write did not start hold-off");

    property p_bresp_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped before bready");
endmodule

// ### src/tcp_pin_sync.sv
// three-stage synchroniser for a pin from outside the aclk domain
// output follows once the second and third stages agree
`timescale 1ns/1ps
module tcp_pin_sync
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule

// ### src/tcp_pkg.sv
// constants for the three-wire configuration port host controller
// assumes a 250 MHz aclk and a byte-wide device register space
package tcp_pkg;

    // clock and timing
    localparam int CLK_FREQ_KHZ   = 250000;
    localparam int SRST_WAIT_MS   = 5;
    localparam int SRST_WAIT_CYC  = SRST_WAIT_MS * CLK_FREQ_KHZ;
    localparam int SCLK_HALF_CYC  = 8;

    // frame layout
    localparam logic [4:0] INSTR_BITS = 5'h10;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] LAST_BIT   = 5'h17;
    localparam logic [4:0] POS_LSB_IN = 5'h08;

    // device register map
    localparam logic [14:0] DEV_PORT_CFG   = 15'h0000;
    localparam logic [14:0] DEV_SEC_CHSEL  = 15'h0005;
    localparam logic [14:0] DEV_CH_INDEX   = 15'h0008;
    localparam logic [14:0] DEV_OUT_MODE   = 15'h0561;
    localparam logic [14:0] DEV_INBUF_CTRL = 15'h1A4C;
    localparam logic [7:0]  OUT_MODE_RST   = 8'h01;
    localparam logic [7:0]  SRST_MASK      = 8'h81;
    localparam logic [7:0]  LSB_MASK       = 8'h42;

    // controller register map over AXI4-Lite
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam int CTRL_GO   = 0;
    localparam int CTRL_READ = 1;
    localparam int ST_BUSY   = 0;
    localparam int ST_RWAIT  = 1;
    localparam int ST_LSB    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        S_IDLE,
        S_SHIFT,
        S_DONE,
        S_RWAIT
    } tcp_state_t;

    // serial position of a frame bit: instruction above data, 24 bits
    function automatic logic [4:0] tcp_bit_pos(input logic [4:0] idx,
                                               input logic       lsb);
        if (!lsb)
            return 5'(LAST_BIT - idx);
        else if (idx < INSTR_BITS)
            return 5'(idx + POS_LSB_IN);
        else
            return 5'(idx - INSTR_BITS);
    endfunction

endpackage

// ### src/tcp_tick_div.sv
// divider giving a one-cycle tick every half serial clock period
// assumes run is held high for the whole frame; restarts when low
`timescale 1ns/1ps
module tcp_tick_div
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic run,
    output logic      tick
);
    import tcp_pkg::*;

    logic [7:0] count;
    wire        at_end = (count == 8'(SCLK_HALF_CYC - 1));

    assign tick = run && at_end;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run || at_end)
            count <= 8'h00;
        else
            count <= 8'(count + 8'h01);
    end
endmodule

// ### verification/tb_three_wire_config_port.sv
// self-checking bench for the three-wire configuration port host
// assumes tcp_host_ctrl and tcp_dev_model are compiled before it
`timescale 1ns/1ps
module tb_three_wire_config_port;
    import tcp_pkg::*;

    localparam int RST_W = 50;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr, v1, v2;
    logic [31:0] wdata, rdata, rd_last;
    logic [1:0]  bresp, rresp;
    logic        sclk, chip_select_n, sdio_o, sdio_oe, sdio;
    logic        dev_o, dev_oe, idle_pat, lsb_mode;
    logic [23:0] sh;
    logic [1:0]  exp_b [$];
    logic [65:0] exp_r [$];
    logic [23:0] exp_f [$];
    logic [7:0]  regs [5] = '{REG_CTRL, REG_ADDR, REG_WDATA, REG_STATUS,
                              REG_RDATA};
    int          num_errors = 0, num_checks = 0, nb = 0, seed = 69;
    time         t_sclk, t_csr;

    // released line shows a changing pattern, never the last value
    assign sdio = sdio_oe ? sdio_o : (dev_oe ? dev_o : idle_pat);

    tcp_host_ctrl #(.RST_WAIT_CYCLES(RST_W)) tcp_host_ctrl_inst
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sclk(sclk), .chip_select_n(chip_select_n),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdio_i(sdio)
    );

    tcp_dev_model tcp_dev_model_inst
    (
        .chip_select_n(chip_select_n), .sclk(sclk), .sdio(sdio),
        .dev_o(dev_o), .dev_oe(dev_oe)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        exp_b.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (awready)
            begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready)
            begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do
            @(posedge aclk);
        while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m, input logic [1:0] r);
        exp_r.push_back({r, m, e});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!rvalid);
        rd_last = rdata;
        rready <= 1'b0;
    endtask

    task automatic wait_idle;
        do
            axi_rd(REG_STATUS, 32'h0, 32'h0, RESP_OKAY);
        while (rd_last[ST_BUSY] === 1'b1);
    endtask

    // only assigned device addresses are used, spare bits as zero
    task automatic frame(input logic rw, input logic [14:0] a,
                         input logic [7:0] d);
        logic [23:0] s;
        s = {rw, a, d};
        if (lsb_mode)
            for (int i = 0; i < 24; i++)
                s[23 - i] = i < 15 ? a[i] : (i == 15 ? rw : d[i % 16]);
        exp_f.push_back(s);
        axi_wr(REG_ADDR, {17'h0, a}, RESP_OKAY);
        axi_wr(REG_WDATA, {24'h0, d}, RESP_OKAY);
        axi_wr(REG_CTRL, {30'h0, rw, 1'b1}, RESP_OKAY);
        wait_idle();
        if (rw)
            axi_rd(REG_RDATA, {24'h0, d}, 32'hFF, RESP_OKAY);
    endtask

    always #2 aclk = ~aclk;

    always @(posedge aclk)
    begin
        idle_pat <= ~idle_pat;
        if (bvalid && bready)
            chk(bresp, exp_b.pop_front(), "bresp");
        if (rvalid && rready)
        begin
            chk(rresp, exp_r[0][65:64], "rresp");
            chk(rdata & exp_r[0][63:32], exp_r[0][31:0], "rdata");
            void'(exp_r.pop_front());
        end
        if (sdio_oe && dev_oe)
            chk(1, 0, "data line driven from both ends");
    end

    always @(negedge chip_select_n)
    begin
        nb = 0;
        chk(sclk, 0, "sclk idle at frame start");
    end

    always @(posedge sclk)
    begin
        if (!chip_select_n)
        begin
            if (nb > 0)
                chk($time - t_sclk, 64, "sclk period");
            t_sclk = $time;
            sh = {sh[22:0], sdio};
            nb++;
        end
    end

    always @(posedge chip_select_n)
    begin
        if (aresetn === 1'b1)
        begin
            t_csr = $time;
            chk(nb, 24, "bits per frame");
            chk(sh, exp_f.pop_front(), "serial frame");
        end
    end

    initial
    begin
        aclk = 0;
        aresetn = 0;
        idle_pat = 0;
        lsb_mode = 0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i])
            axi_rd(regs[i], 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        axi_rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        axi_wr(8'h14, $random(seed), RESP_SLVERR);
        frame(1'b1, DEV_OUT_MODE, OUT_MODE_RST);
        v1 = 8'($random(seed));
        v2 = ~v1;
        frame(1'b0, DEV_CH_INDEX, 8'h03);
        frame(1'b0, DEV_INBUF_CTRL, v1);
        frame(1'b0, DEV_CH_INDEX, 8'h02);
        frame(1'b1, DEV_INBUF_CTRL, v1);
        frame(1'b0, DEV_INBUF_CTRL, v2);
        frame(1'b0, DEV_CH_INDEX, 8'h03);
        frame(1'b1, DEV_INBUF_CTRL, v1);
        frame(1'b0, DEV_SEC_CHSEL, v2);
        frame(1'b1, DEV_OUT_MODE, OUT_MODE_RST);
        // second start while busy must not launch another frame
        exp_f.push_back({1'b0, DEV_SEC_CHSEL, v1});
        axi_wr(REG_ADDR, {17'h0, DEV_SEC_CHSEL}, RESP_OKAY);
        axi_wr(REG_WDATA, {24'h0, v1}, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        wait_idle();
        frame(1'b1, DEV_SEC_CHSEL, v1);
        frame(1'b0, DEV_PORT_CFG, LSB_MASK);
        lsb_mode = 1'b1;
        axi_rd(REG_STATUS, 32'h4, 32'h7, RESP_OKAY);
        frame(1'b1, DEV_PORT_CFG, LSB_MASK);
        frame(1'b1, DEV_INBUF_CTRL, v1);
        frame(1'b0, DEV_PORT_CFG, SRST_MASK);
        lsb_mode = 1'b0;
        chk(($time - t_csr) / 4 >= RST_W, 1, "hold-off short");
        chk(($time - t_csr) / 4 <= RST_W + 40, 1, "hold-off long");
        axi_rd(REG_STATUS, 32'h0, 32'h7, RESP_OKAY);
        frame(1'b1, DEV_PORT_CFG, 8'h00);
        frame(1'b1, DEV_INBUF_CTRL, 8'h00);
        frame(1'b1, DEV_OUT_MODE, OUT_MODE_RST);
        summarize();
    end

    initial
    begin
        #200000;
        chk(0, 1, "timeout");
        summarize();
    end
endmodule

// ### verification/tcp_dev_model.sv
// behavioural far-end device of the three-wire configuration port
// assumes the bench resolves the shared data line from both enables
`timescale 1ns/1ps
module tcp_dev_model
(
    input  wire logic chip_select_n,
    input  wire logic sclk,
    input  wire logic sdio,
    output logic      dev_o,
    output logic      dev_oe
);
    logic [7:0]  cfg, sec, chidx, omode, rbyte;
    logic [7:0]  inbuf [2];
    logic [23:0] fr;
    logic [14:0] addr;
    logic        lsb;
    int          n;

    task automatic defaults;
        cfg = 8'h00;
        sec = 8'h00;
        chidx = 8'h03;
        omode = 8'h01;
        inbuf = '{8'h00, 8'h00};
    endtask

    function automatic logic [7:0] rd(input logic [14:0] a);
        case (a)
            15'h0000: return cfg;
            15'h0005: return sec;
            15'h0008: return chidx;
            15'h0561: return omode;
            15'h1A4C: return chidx[0] ? inbuf[0] : inbuf[1];
            default:  return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        case (a)
            15'h0000:
                if ((d & 8'h81) != 8'h00)
                    defaults();
                else
                    cfg = d & 8'h66;
            15'h0005: sec = d;
            15'h0008: chidx = d;
            15'h0561: omode = d;
            15'h1A4C:
            begin
                if (chidx[0])
                    inbuf[0] = d;
                if (chidx[1])
                    inbuf[1] = d;
            end
            default: ;
        endcase
    endtask

    // frame bit n lands so that rw is bit 23, address 22:8, data 7:0
    function automatic int pos(input int i);
        if (!lsb)
            return 23 - i;
        return i < 15 ? i + 8 : (i == 15 ? 23 : i - 16);
    endfunction

    initial
    begin
        defaults();
        n = 0;
        lsb = 1'b0;
        dev_o = 1'b0;
        dev_oe = 1'b0;
    end

    always @(negedge chip_select_n)
    begin
        n = 0;
        lsb = cfg[1] | cfg[6];
    end

    always @(posedge chip_select_n)
    begin
        n = 0;
        dev_oe <= 1'b0;
    end

    always @(posedge sclk)
    begin
        if (!chip_select_n)
        begin
            fr[pos(n)] = sdio;
            n = n + 1;
            if (n == 16)
                addr = fr[22:8];
            if (n == 24)
            begin
                if (!fr[23])
                    wr(addr, fr[7:0]);
                addr = cfg[2] ? addr + 15'h1 : addr - 15'h1;
                n = 16;
            end
            if (n == 16)
                rbyte = rd(addr);
        end
    end

    always @(negedge sclk)
    begin
        if (!chip_select_n && n >= 16 && fr[23])
        begin
            dev_oe <= 1'b1;
            dev_o <= rbyte[lsb ? n - 16 : 23 - n];
        end
    end
endmodule
